// *** snbuf_pkg.sv ***
/*
  Package of the nibble capture and buffer block: timing constants, frame
  layout, buffer geometry and reset values.
  Assumes a 50 MHz system clock.
*/
package snbuf_pkg;
  // Clock and nominal tick
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned TICK_NS         = 3000;   // Nominal tick time in ns
  localparam int unsigned CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;
  localparam int unsigned TICK_CYC        = TICK_NS / CLK_PERIOD_NS;
  // Inhibit: 5 ticks * 0.75, least time so round up
  localparam int unsigned INHIBIT_TICKS_X100 = 5 * 75;
  localparam int unsigned INHIBIT_CYC     = (INHIBIT_TICKS_X100 * TICK_CYC + 99) / 100;
  // Timeout: 56 ticks * 1.25
  localparam int unsigned TIMEOUT_TICKS_X100 = 56 * 125;
  localparam int unsigned TIMEOUT_CYC     = (TIMEOUT_TICKS_X100 * TICK_CYC) / 100;
  // Frame layout
  localparam int unsigned FRAME_NIBBLES   = 9;
  localparam int unsigned DATA_NIBBLES    = 6;
  localparam int unsigned MAX_DATA_NIBBLES = 8;
  localparam int unsigned CAL_TICKS       = 56;
  localparam int unsigned SYNC_MIN_TICKS  = 12;   // Shortest legal nibble, value 0
  // Buffer geometry
  localparam int unsigned BUF_ENTRIES     = 32;
  localparam int unsigned ENTRY_BITS      = 16;
  localparam int unsigned ADDR_LSB_16     = 6;    // 64 bytes
  localparam int unsigned ADDR_LSB_32     = 7;    // 128 bytes
  localparam int unsigned CNT_W           = 16;
  localparam logic [15:0] TICK_RESET_VAL  = 16'h0000;
  localparam logic [3:0]  CRC_SEED        = 4'h5;
endpackage : snbuf_pkg

// *** snbuf_fifo.sv ***
/*
  Parameterised valid/ready FIFO placed between capture and the buffer move.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/10ps
module snbuf_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  // Handshakes; full and empty come straight from the count
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];

  // Storage, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : snbuf_fifo

// *** snbuf_top.sv ***
/*
  Single-edge nibble receive path: tick counter, edge capture, inhibit and
  timeout compares, rising-edge request pulse, circular buffer move engine
  and a frame checker over the buffered nibbles.
  Assumes rx_pin already synchronous to clk and a 50 MHz clock.
  // Behaviour
  // - Falling edge starts nibble; interval gives value
  // - Tick counter counts up, clears on capture
  // - Falling edge latches count, clears counter
  // - Falling edge sets nibble trigger high
  // - Inhibit compare drops trigger after inhibit
  // - Edges during trigger high start no move
  // - Timeout after 56 ticks times 1.25
  // - Trigger rising edge gives one request pulse
  // - Each request writes count, advances pointer
  // - Pointer wraps to buffer start
  // - Buffer holds at least two frames
  // - Base aligned to buffer size
  // - Frame is nine nibbles, 24 data bits
  // - 16-bit entries: 64 bytes, 6 zero bits
  // - 32-bit entries: 128 bytes, 7 zero bits
  // - Interrupt after each full frame of moves
  // - Check calibration, nibbles and CRC
  // - Store data after good checks, optional interrupt
  // - Report loss, sync, drift, CRC, nibble errors
  // - Up to eight data nibbles supported
  // - Inhibit is five ticks times 0.75
  // - Delay frame interrupt to align frame end
*/
`timescale 1ns/10ps
module snbuf_top
  import snbuf_pkg::*;
#(
  parameter int unsigned ENTRY_W   = ENTRY_BITS,
  parameter int unsigned ENTRIES   = BUF_ENTRIES,
  parameter int unsigned FRAME_LEN = FRAME_NIBBLES,
  parameter int unsigned NDATA     = DATA_NIBBLES
) (
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  input  wire logic                       rx_pin,
  input  wire logic                       frame_sync_en,
  input  wire logic [$clog2(ENTRIES)-1:0] rd_index,
  output logic      [ENTRY_W-1:0]         rd_entry_q,
  output logic                            nibble_trigger_out,
  output logic                            debug_trigger_out,
  output logic                            dma_request_out,
  output logic                            frame_irq_q,
  output logic                            timeout_irq_q,
  output logic                            data_valid_q,
  output logic      [4*MAX_DATA_NIBBLES-1:0] data_q,
  output logic      [3:0]                 status_nibble_q,
  output logic      [5:0]                 error_flags_q,
  output logic      [$clog2(ENTRIES)-1:0] wr_ptr_q
);
  localparam int unsigned PW = $clog2(ENTRIES);

  // CRC step over one nibble, used for every data nibble
  function automatic logic [3:0] snbuf_crc4(input logic [3:0] crc, input logic [3:0] nib);
    logic [3:0] x;
    x = crc ^ nib;
    for (int i = 0; i < 4; i++) begin
      x = x[3] ? {x[2:0], 1'b0} ^ 4'hD : {x[2:0], 1'b0};
    end
    return x;
  endfunction : snbuf_crc4

  // Nibble value from ticks: ticks/tick minus 12
  function automatic logic [4:0] snbuf_nib(input logic [ENTRY_W-1:0] t, input logic [ENTRY_W-1:0] tick);
    logic [ENTRY_W-1:0] q;
    q = (tick == '0) ? '0 : ENTRY_W'((t + (tick >> 1)) / tick);
    if (q < ENTRY_W'(SYNC_MIN_TICKS) || q > ENTRY_W'(SYNC_MIN_TICKS + 15)) begin
      return 5'h10;
    end
    return {1'b0, 4'(q - ENTRY_W'(SYNC_MIN_TICKS))};
  endfunction : snbuf_nib

  // Calibration pulse recognised when within 25 percent of 56 ticks
  function automatic logic cal_like(input logic [ENTRY_W-1:0] t);
    return (t >= ENTRY_W'(CAL_TICKS * TICK_CYC * 3 / 4)) && (t <= ENTRY_W'(TIMEOUT_CYC));
  endfunction : cal_like

  function automatic logic [ENTRY_W-1:0] calib_tick();
    return ENTRY_W'(TICK_CYC);
  endfunction : calib_tick

  logic [CNT_W-1:0] tick_reset_counter_q;
  logic [CNT_W-1:0] edge_capture_cell_q;
  logic             rx_q;
  logic             fall;
  logic             trig_q;
  logic             trig_d1_q;
  logic             timeout_armed_q;
  logic             fifo_ready;
  logic             fifo_valid;
  logic [ENTRY_W-1:0] fifo_data;
  logic [ENTRY_W-1:0] buf_q [ENTRIES];
  logic [PW-1:0]    moves_q;
  logic [PW-1:0]    frame_len_q;
  logic             check_q;
  logic [PW-1:0]    check_base_q;

  assign fall = rx_q && !rx_pin;

  // Input history for edge detection
  always_ff @(posedge clk) begin
    if (!reset_n) rx_q <= 1'b1;
    else          rx_q <= rx_pin;
  end

  // Saturating tick count, cleared by the capture cell
  always_ff @(posedge clk) begin
    if (!reset_n)  tick_reset_counter_q <= TICK_RESET_VAL;
    else if (fall) tick_reset_counter_q <= TICK_RESET_VAL;
    else if (tick_reset_counter_q != '1) tick_reset_counter_q <= tick_reset_counter_q + 1'b1;
  end

  // Capture every edge, even inside the inhibit window
  always_ff @(posedge clk) begin
    if (!reset_n)  edge_capture_cell_q <= '0;
    else if (fall) edge_capture_cell_q <= tick_reset_counter_q;
  end

  // Trigger: set on edge, cleared by inhibit compare
  always_ff @(posedge clk) begin
    if (!reset_n) trig_q <= 1'b0;
    else if (fall) trig_q <= 1'b1;
    else if (tick_reset_counter_q == CNT_W'(INHIBIT_CYC - 1)) trig_q <= 1'b0;
  end

  // Request pulse on trigger rising edge only; edges while high are absorbed
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      trig_d1_q          <= 1'b0;
      dma_request_out    <= 1'b0;
      nibble_trigger_out <= 1'b0;
      debug_trigger_out  <= 1'b0;
    end else begin
      trig_d1_q          <= trig_q;
      dma_request_out    <= trig_q && !trig_d1_q;
      nibble_trigger_out <= trig_q;
      debug_trigger_out  <= trig_q;
    end
  end

  // Timeout: one event per silent stretch
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      timeout_armed_q <= 1'b0;
      timeout_irq_q   <= 1'b0;
    end else begin
      timeout_irq_q <= 1'b0;
      if (fall) begin
        timeout_armed_q <= 1'b1;
      end else if (timeout_armed_q && tick_reset_counter_q == CNT_W'(TIMEOUT_CYC)) begin
        timeout_irq_q   <= 1'b1;
        timeout_armed_q <= 1'b0;
      end
    end
  end

  // Elasticity between the request and the memory write; when full a request
  // is dropped, which only happens if the move side stalls for 8 nibbles
  snbuf_fifo #(
    .WIDTH (ENTRY_W),
    .DEPTH (8)
  ) u_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (dma_request_out),
    .in_ready  (fifo_ready),
    .in_data   (ENTRY_W'(edge_capture_cell_q)),
    .out_valid (fifo_valid),
    .out_ready (!check_q),
    .out_data  (fifo_data)
  );

  // Circular buffer write, pointer wraps at power-of-two size
  always_ff @(posedge clk) begin
    if (fifo_valid && !check_q) begin
      buf_q[wr_ptr_q] <= fifo_data;
    end
  end

  // Pointer is the offset from an aligned base, so wrap is natural overflow
  always_ff @(posedge clk) begin
    if (!reset_n) wr_ptr_q <= '0;
    else if (fifo_valid && !check_q) wr_ptr_q <= wr_ptr_q + 1'b1;
  end

  // Move count; interrupt after each frame, resized to align to frame end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      moves_q      <= '0;
      frame_len_q  <= PW'(FRAME_LEN);
      frame_irq_q  <= 1'b0;
      check_q      <= 1'b0;
      check_base_q <= '0;
    end else begin
      frame_irq_q <= 1'b0;
      check_q     <= 1'b0;
      if (fifo_valid && !check_q) begin
        if (moves_q == frame_len_q - 1'b1) begin
          moves_q      <= '0;
          frame_irq_q  <= 1'b1;
          check_q      <= 1'b1;
          check_base_q <= wr_ptr_q - PW'(FRAME_LEN - 1);
          frame_len_q  <= PW'(FRAME_LEN);
        end else begin
          moves_q <= moves_q + 1'b1;
        end
        // Calibration seen mid-frame: next interrupt ends after that frame
        if (frame_sync_en && snbuf_nib(fifo_data, calib_tick()) == 5'h10 && cal_like(fifo_data)
            && moves_q != '0) begin
          moves_q     <= '0;
          frame_len_q <= PW'(FRAME_LEN - 1);
        end
      end
    end
  end

  // Frame checker, in the same cycle as the frame interrupt
  always_ff @(posedge clk) begin : check_blk
    logic [ENTRY_W-1:0] tick;
    logic [4:0]         n;
    logic [3:0]         crc;
    logic [5:0]         err;
    logic [4*MAX_DATA_NIBBLES-1:0] dat;
    tick = '0;
    n    = '0;
    crc  = CRC_SEED;
    err  = '0;
    dat  = '0;
    if (!reset_n) begin
      data_valid_q    <= 1'b0;
      data_q          <= '0;
      status_nibble_q <= '0;
      error_flags_q   <= '0;
    end else begin
      data_valid_q <= 1'b0;
      if (check_q) begin
        tick = ENTRY_W'(buf_q[check_base_q] / ENTRY_W'(CAL_TICKS));
        if (!cal_like(buf_q[check_base_q])) err[1] = 1'b1;          // Sync loss
        if (tick + (tick >> 3) < calib_tick() || tick > calib_tick() + (calib_tick() >> 3)) begin
          err[2] = 1'b1; // Clock drift beyond 1/8
        end
        for (int i = 1; i <= NDATA + 2; i++) begin
          n = snbuf_nib(buf_q[check_base_q + PW'(i)], tick);
          if (n[4]) err[4] = 1'b1;
          if (i == 1) status_nibble_q <= n[3:0];
          else if (i <= NDATA + 1) begin
            crc = snbuf_crc4(crc, n[3:0]);
            dat = {dat[4*MAX_DATA_NIBBLES-5:0], n[3:0]};
          end else if (n[3:0] != crc) err[3] = 1'b1;
        end
        if (n[4]) err[5] = 1'b1; // Bad CRC nibble treated as serial error
        error_flags_q <= error_flags_q | err;
        if (err == '0) begin
          data_q       <= dat;
          data_valid_q <= 1'b1;
        end
      end
      if (timeout_irq_q) error_flags_q[0] <= 1'b1; // Signal loss
    end
  end

  // Read port into buffer contents
  always_ff @(posedge clk) begin
    if (!reset_n) rd_entry_q <= '0;
    else          rd_entry_q <= buf_q[rd_index];
  end

  // Checks
  property p_req_one_cycle;
    @(posedge clk) disable iff (!reset_n) dma_request_out |=> !dma_request_out;
  endproperty
  a_req_one_cycle: assert property (p_req_one_cycle) else $error("request longer than one cycle");

  property p_capture;
    @(posedge clk) disable iff (!reset_n) fall |=> edge_capture_cell_q == $past(tick_reset_counter_q)
      && tick_reset_counter_q == '0;
  endproperty
  a_capture: assert property (p_capture) else $error("capture or clear missed");

  property p_trig_set;
    @(posedge clk) disable iff (!reset_n) fall |=> trig_q;
  endproperty
  a_trig_set: assert property (p_trig_set) else $error("trigger not set on edge");

  property p_inhibit;
    @(posedge clk) disable iff (!reset_n)
      (trig_q && !fall && tick_reset_counter_q == CNT_W'(INHIBIT_CYC - 1)) |=> !trig_q;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("trigger not cleared at inhibit");

  property p_no_req_high;
    @(posedge clk) disable iff (!reset_n) (trig_q && trig_d1_q) |=> !dma_request_out;
  endproperty
  a_no_req_high: assert property (p_no_req_high) else $error("request while trigger high");

  property p_timeout;
    @(posedge clk) disable iff (!reset_n)
      (timeout_armed_q && !fall && tick_reset_counter_q == CNT_W'(TIMEOUT_CYC)) |=> timeout_irq_q;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not raised");

  property p_ptr_step;
    @(posedge clk) disable iff (!reset_n) (fifo_valid && !check_q) |=> wr_ptr_q == $past(wr_ptr_q) + 1'b1;
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer did not advance");

  property p_tick_up;
    @(posedge clk) disable iff (!reset_n)
      (!fall && tick_reset_counter_q != '1) |=> tick_reset_counter_q == $past(tick_reset_counter_q) + 1'b1;
  endproperty
  a_tick_up: assert property (p_tick_up) else $error("tick counter stalled");

  // Check runs exactly one cycle, so the buffer move stalls only once
  sequence s_frame_done;
    check_q ##1 !check_q;
  endsequence
  property p_irq_check;
    @(posedge clk) disable iff (!reset_n) frame_irq_q |-> s_frame_done;
  endproperty
  a_irq_check: assert property (p_irq_check) else $error("frame check not started");

  property p_no_drop;
    @(posedge clk) disable iff (!reset_n) dma_request_out |-> fifo_ready;
  endproperty
  a_no_drop: assert property (p_no_drop) else $error("request dropped at full buffer");
endmodule : snbuf_top

// *** snbuf_sensor_model.sv ***
/*
  Behavioural sensor model that drives the single nibble line.
  Assumes go is a one-cycle pulse given just after a rising clock edge,
  with len_cyc and glitch valid alongside go, as both are latched on that edge.
*/
`timescale 1ns/10ps
module snbuf_sensor_model
  import snbuf_pkg::*;
#(
  parameter int unsigned LOW_CYC = 4 * TICK_CYC
) (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [15:0] len_cyc,
  input  wire logic        glitch,
  output logic             rx_pin
);
  int unsigned i;
  logic [15:0] len_l;
  logic        gl_l;

  // Line idles high behind its pull-up
  initial rx_pin = 1'b1;

  // One nibble per go: falling edge, low phase, high until the next edge
  always @(posedge clk) begin
    if (go === 1'b1) begin
      // Latched, as the bench may load the next nibble in the last step
      len_l = len_cyc;
      gl_l  = glitch;
      #1 rx_pin = 1'b0;
      for (i = 1; i < len_l; i++) begin
        @(posedge clk);
        #1;
        // Short low phase on request, so noise lands inside the inhibit
        if (i == (gl_l ? 100 : LOW_CYC)) rx_pin = 1'b1;
        if (gl_l && (i == 200 || i == 201)) rx_pin = 1'b0;
        if (gl_l && i == 202) rx_pin = 1'b1;
      end
    end
  end
endmodule : snbuf_sensor_model

// *** sent_nibble_capture_buffer_tb.sv ***
/*
  Self-checking bench of the nibble capture and buffer block.
  Assumes the package, the design files and the sensor model come first.
*/
`timescale 1ns/10ps
module sent_nibble_capture_buffer_tb
  import snbuf_pkg::*;
;
  localparam int unsigned LIMIT = 100_000;
  localparam logic [15:0] L_MIN = 16'(SYNC_MIN_TICKS * TICK_CYC);
  logic        clk;
  logic        reset_n;
  logic        rx_pin;
  logic        go;
  logic        glitch;
  logic        frame_sync_en;
  logic [15:0] len_cyc;
  logic [4:0]  rd_index;
  logic [15:0] rd_entry_q;
  logic        nibble_trigger_out, debug_trigger_out, dma_request_out, req_prev;
  logic        frame_irq_q, timeout_irq_q, data_valid_q;
  logic [31:0] data_q;
  logic [3:0]  status_nibble_q;
  logic [5:0]  error_flags_q;
  logic [4:0]  wr_ptr_q;
  int unsigned err_count, cmp_count, req_cnt, req_wide, firq_cnt, tout_cnt;
  int unsigned trig_run, last_run, dbg_bad, cyc, n_edge;

  // 50 MHz clock
  always #10 clk = ~clk;

  snbuf_top u_dut (
    .clk                (clk),
    .reset_n            (reset_n),
    .rx_pin             (rx_pin),
    .frame_sync_en      (frame_sync_en),
    .rd_index           (rd_index),
    .rd_entry_q         (rd_entry_q),
    .nibble_trigger_out (nibble_trigger_out),
    .debug_trigger_out  (debug_trigger_out),
    .dma_request_out    (dma_request_out),
    .frame_irq_q        (frame_irq_q),
    .timeout_irq_q      (timeout_irq_q),
    .data_valid_q       (data_valid_q),
    .data_q             (data_q),
    .status_nibble_q    (status_nibble_q),
    .error_flags_q      (error_flags_q),
    .wr_ptr_q           (wr_ptr_q)
  );

  snbuf_sensor_model u_sensor (
    .clk     (clk),
    .go      (go),
    .len_cyc (len_cyc),
    .glitch  (glitch),
    .rx_pin  (rx_pin)
  );

  // Port watchers; counting here keeps the scenarios free of fork races
  always @(posedge clk) begin
    if (dma_request_out === 1'b1) req_cnt++;
    if (dma_request_out === 1'b1 && req_prev === 1'b1) req_wide++;
    req_prev = dma_request_out;
    if (frame_irq_q === 1'b1) firq_cnt++;
    if (timeout_irq_q === 1'b1) tout_cnt++;
    if (debug_trigger_out !== nibble_trigger_out) dbg_bad++;
    if (nibble_trigger_out === 1'b1) begin
      trig_run++;
    end else if (trig_run != 0) begin
      last_run = trig_run;
      trig_run = 0;
    end
    cyc++;
    if (cyc == LIMIT) begin
      err_count++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  // One nibble of len cycles; returns just before the next edge is due
  task automatic send_nib(input logic [15:0] len, input logic gl);
    len_cyc = len;
    glitch = gl;
    go = 1'b1;
    n_edge++;
    @(posedge clk);
    #1 go = 1'b0;
    repeat (len - 1) @(posedge clk);
    #1;
  endtask : send_nib

  task automatic rd_entry(input logic [4:0] idx, output logic [15:0] v);
    rd_index = idx;
    repeat (2) @(posedge clk);
    #1 v = rd_entry_q;
  endtask : rd_entry

  task automatic t_reset_values();
    chk({12'h000, error_flags_q, wr_ptr_q, status_nibble_q, data_valid_q, frame_irq_q,
         timeout_irq_q, dma_request_out, nibble_trigger_out}, 32'h0000_0000);
    chk(data_q, 32'h0000_0000);
  endtask : t_reset_values

  task automatic t_trigger();
    send_nib(L_MIN, 1'b0);
    chk(last_run, INHIBIT_CYC);
    chk(req_cnt, 32'h0000_0001);
    chk(req_wide + dbg_bad, 32'h0000_0000);
  endtask : t_trigger

  // Shortest, longest and calibration intervals; the unknown offset cancels
  task automatic t_capture();
    logic [15:0] lens [4];
    logic [15:0] a;
    logic [15:0] b;
    logic [4:0]  p;
    lens = '{L_MIN, 16'(27 * TICK_CYC), 16'(CAL_TICKS * TICK_CYC), L_MIN};
    p = wr_ptr_q;
    for (int k = 0; k < 4; k++) send_nib(lens[k], 1'b0);
    chk({27'h0, wr_ptr_q}, {27'h0, p + 5'd4});
    for (int k = 2; k < 4; k++) begin
      rd_entry(p + 5'(k - 1), a);
      rd_entry(p + 5'(k), b);
      chk(32'(b - a), 32'(lens[k - 1] - lens[k - 2]));
    end
  endtask : t_capture

  task automatic t_glitch();
    int unsigned r0;
    r0 = req_cnt;
    send_nib(L_MIN, 1'b1);
    chk(req_cnt - r0, 32'h0000_0001);
    chk({27'h0, wr_ptr_q}, {27'h0, 5'(n_edge)});
  endtask : t_glitch

  // Three frames of moves; the pointer wraps past the 32nd entry
  task automatic t_frame();
    int unsigned f0;
    f0 = firq_cnt;
    repeat (3 * FRAME_NIBBLES) send_nib(L_MIN, 1'b0);
    chk(firq_cnt - f0, 32'h0000_0003);
    chk(req_cnt, n_edge);
    chk({27'h0, wr_ptr_q}, {27'h0, 5'(n_edge)});
  endtask : t_frame

  // Calibration length lands mid-frame; interrupt then follows 8 more moves,
  // where without realignment it would come on the very next move
  task automatic t_sync();
    int unsigned f0;
    frame_sync_en = 1'b1;
    f0 = firq_cnt;
    send_nib(16'(CAL_TICKS * TICK_CYC), 1'b0);
    repeat (FRAME_NIBBLES - 1) send_nib(16'(5 * TICK_CYC), 1'b0);
    chk(firq_cnt - f0, 32'h0000_0000);
    send_nib(16'(5 * TICK_CYC), 1'b0);
    chk(firq_cnt - f0, 32'h0000_0001);
    frame_sync_en = 1'b0;
  endtask : t_sync

  task automatic t_timeout();
    int unsigned k;
    chk(tout_cnt, 32'h0000_0000);
    send_nib(L_MIN, 1'b0);
    k = L_MIN - 1;
    while (tout_cnt == 0 && k < TIMEOUT_CYC + 50) begin
      @(posedge clk);
      #1 k++;
    end
    chk(32'(k >= TIMEOUT_CYC && k <= TIMEOUT_CYC + 6), 32'h0000_0001);
    repeat (3) @(posedge clk);
    #1;
    chk(tout_cnt, 32'h0000_0001);
    chk({31'h0, error_flags_q[0]}, 32'h0000_0001);
  endtask : t_timeout

  // Main sequence
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    go = 1'b0;
    glitch = 1'b0;
    frame_sync_en = 1'b0;
    len_cyc = L_MIN;
    rd_index = 5'h00;
    repeat (4) @(posedge clk);
    #1 reset_n = 1'b1;
    t_reset_values();
    t_trigger();
    t_capture();
    t_glitch();
    t_frame();
    t_sync();
    t_timeout();
    stop_test();
  end
endmodule : sent_nibble_capture_buffer_tb
